// ### asu_baud_gen.sv
// Purpose: modulo divider giving the 16x oversampling tick
// Assumes: div held stable between updates
// Notes:   tick is a one-cycle enable pulse
`timescale 1ns/1ns
`default_nettype none
module asu_baud_gen #(
    parameter int W = 13
) (
    input  wire logic         clk,
    input  wire logic         reset_n,
    input  wire logic         run,
    input  wire logic [W-1:0] div,
    output logic              tick
);
    logic [W-1:0] cnt;   // cycles since last tick

    always_ff @(posedge clk) begin
        if (!reset_n || !run || div == '0) begin
            cnt  <= '0;
            tick <= 1'b0;
        // a divisor cut below the count must wrap at once, not run to the top
        end else if (cnt >= W'(div - 1'b1)) begin
            cnt  <= '0;
            tick <= 1'b1;
        end else begin
            cnt  <= W'(cnt + 1'b1);
            tick <= 1'b0;
        end
    end
endmodule // asu_baud_gen
`default_nettype wire

// ### asu_peer.sv
// Purpose: remote serial node on the pins
// Assumes: lines idle high through pull-ups
// Notes:   tasks run in the caller's process
`timescale 1ns/1ns
`default_nettype none
module asu_peer (
    input  wire logic clk,
    input  wire logic line,
    output logic      rx
);
    // mark level outside frames
    initial rx = 1'b1;
    // start, lsb first, stop; long lows make breaks
    task automatic send(input logic [8:0] v, input int n, input int bc);
        rx <= 1'b0;
        repeat (bc) @(posedge clk);
        for (int k = 0; k < n; k++) begin
            rx <= v[k];
            repeat (bc) @(posedge clk);
        end
        rx <= 1'b1;
        repeat (bc) @(posedge clk);
    endtask
    // sample mid-bit, stop must be high
    task automatic recv(output logic [8:0] v, input int n, input int bc, output logic ok);
        int k;
        v = '0;
        for (k = 0; k < 600 && line; k++) @(posedge clk);
        ok = !line;
        repeat (bc / 2) @(posedge clk);
        for (k = 0; k < n; k++) begin
            repeat (bc) @(posedge clk);
            v[k] = line;
        end
        repeat (bc) @(posedge clk);
        ok = ok && line;
    endtask
endmodule // asu_peer
`default_nettype wire

// ### asu_pkg.sv
// Purpose: shared constants and types of the async serial unit
// Assumes: byte-wide register port, one bus clock
// Notes:   offsets are word indices on the plain register port
package asu_pkg;
    // register offsets
    localparam logic [3:0] ADR_BDH  = 4'h0;
    localparam logic [3:0] ADR_BDL  = 4'h1;
    localparam logic [3:0] ADR_C1   = 4'h2;
    localparam logic [3:0] ADR_C2   = 4'h3;
    localparam logic [3:0] ADR_S1   = 4'h4;
    localparam logic [3:0] ADR_S2   = 4'h5;
    localparam logic [3:0] ADR_C3   = 4'h6;
    localparam logic [3:0] ADR_DAT  = 4'h7;
    localparam logic [3:0] ADR_SOPT = 4'h8;
    // reset values
    localparam logic [7:0] RST_BDH  = 8'h00;
    localparam logic [7:0] RST_BDL  = 8'h04;
    localparam logic [7:0] RST_ZERO = 8'h00;
    // high divisor register fields
    localparam int BDH_LBKIE = 7;
    localparam int BDH_EDGIE = 6;
    localparam int BR_HI_W   = 5;
    // control one fields
    localparam int C1_LOOPBACK_SELECT = 7;
    localparam int C1_WFRZ  = 6;
    localparam int C1_RX_SOURCE_SELECT  = 5;
    localparam int C1_M     = 4;
    localparam int C1_WAKE  = 3;
    localparam int C1_ILT   = 2;
    localparam int C1_PE    = 1;
    localparam int C1_PT    = 0;
    // control two fields
    localparam int C2_TE  = 3;
    localparam int C2_RE  = 2;
    localparam int C2_RWU = 1;
    localparam int C2_SBK = 0;
    // status two / control three / option fields
    localparam int S2_LBK   = 7;
    localparam int S2_EDG   = 6;
    localparam int S2_LONG_BREAK_SELECT = 2;
    localparam int S2_LBKDE = 1;
    localparam int C3_T8    = 6;
    localparam int C3_SINGLE_WIRE_DIRECTION = 5;
    localparam int SOPT_POS = 0;
    // bit timing in oversampling ticks, frame lengths in bits
    localparam logic [3:0] SUB_LAST = 4'hF;
    localparam logic [3:0] SUB_S0   = 4'h7;
    localparam logic [3:0] SUB_S1   = 4'h8;
    localparam logic [3:0] SUB_S2   = 4'h9;
    localparam logic [3:0] LEN_8    = 4'hA;
    localparam logic [3:0] LEN_9    = 4'hB;
    localparam logic [3:0] LEN_BRKX = 4'h3;
    localparam logic [7:0] TICKS_8  = 8'hA0;
    localparam logic [7:0] TICKS_9  = 8'hB0;
    localparam logic [7:0] TICKS_LBK = 8'hB0;
    // receiver states
    typedef enum logic [3:0] {
        RX_IDLE  = 4'b0001,
        RX_START = 4'b0010,
        RX_DATA  = 4'b0100,
        RX_STOP  = 4'b1000
    } asu_rx_e;
    // register port request
    typedef struct packed {
        logic [3:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } asu_bus_s;
    // two-way pin drive
    typedef struct packed {
        logic out;
        logic oe;
    } asu_pin_s;
endpackage

// ### asu_sync3.sv
// Purpose: three-stage input synchroniser with agreement filter
// Assumes: input is asynchronous to clk
// Notes:   first stage is read only by the second
`timescale 1ns/1ns
`default_nettype none
module asu_sync3 (
    input  wire logic clk,
    input  wire logic reset_n,
    input  wire logic din,
    output logic      q
);
    logic s1, s2, s3;   // stage chain

    // q follows only once stages two and three agree
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            q  <= 1'b1;
        end else begin
            s1 <= din;
            s2 <= s1;
            s3 <= s2;
            if (s2 == s3) begin
                q <= s3;
            end
        end
    end
endmodule // asu_sync3
`default_nettype wire

// ### asu_top.sv
// Purpose: async serial unit - baud, frame options, tx/rx engines
// Assumes: 50 MHz clk, byte register port, pins async to clk
// Notes:   all slower rates come from the baud tick enable
//
// Summary of operation
// - high divisor buffered until low written
// - zero divisor stops the baud generator
// - generator off until tx or rx enabled
// - break flag request gated by bit seven
// - edge flag request gated by bit six
// - loop mode feeds tx into rx
// - source bit picks internal or single-wire
// - wait freeze halts the baud tick
// - eight or nine bits, lsb first
// - wake bit picks idle or address wakeup
// - idle count starts after start or stop
// - parity generated and checked in msb
// - parity type even or odd
// - pin position bit relocates pins
// - nine byte-wide registers
// - long break send, eleven-bit break detect
// - single-wire direction; loopback frees pin
// - break length ten to fourteen bits
`timescale 1ns/1ns
`default_nettype none
module asu_top
    import asu_pkg::*;
(
    input  wire logic     clk,
    input  wire logic     reset_n,
    input  wire asu_bus_s bus,
    output logic [7:0]    rdata,
    input  wire logic     cpu_wait,
    input  wire logic     rx_a_in,
    input  wire logic     rx_b_in,
    input  wire logic     tx_a_in,
    input  wire logic     tx_b_in,
    output asu_pin_s      tx_a,
    output asu_pin_s      tx_b,
    output logic          lbk_irq,
    output logic          edge_irq
);
    // registers
    logic [7:0] bdh, bdl, c1, c2, c3, sopt;
    logic [BR_HI_W-1:0] br_hi;       // working upper divisor
    logic       started;             // generator released
    logic       s1_seen;             // status read armed
    logic       line_break_flag, edgif, long_break_select, lbkde;
    // transmitter
    logic [13:0] tx_shift;
    logic [3:0]  tx_left, tx_sub;
    logic [8:0]  tx_buf;
    logic        tdre, tc, idle_q, brk_q;
    logic        wake_hit;           // standby release pulse
    // receiver
    asu_rx_e     rx_st;
    logic [3:0]  rx_sub, rx_bit;
    logic [8:0]  rx_shift, rdat;
    logic [1:0]  samp;
    logic        rx_nf, rdrf, ovr, nf, fe, pf, idle, idle_arm, rx_prev;
    logic [7:0]  idle_cnt, lbk_cnt;

    // register decode
    wire wr_bdh = bus.wr && bus.addr == ADR_BDH;
    wire wr_bdl = bus.wr && bus.addr == ADR_BDL;
    wire wr_c1  = bus.wr && bus.addr == ADR_C1;
    wire wr_c2  = bus.wr && bus.addr == ADR_C2;
    wire wr_s2  = bus.wr && bus.addr == ADR_S2;
    wire wr_c3  = bus.wr && bus.addr == ADR_C3;
    wire wr_dat = bus.wr && bus.addr == ADR_DAT;
    wire wr_opt = bus.wr && bus.addr == ADR_SOPT;
    wire rd_s1  = bus.rd && bus.addr == ADR_S1;
    wire rd_dat = bus.rd && bus.addr == ADR_DAT;

    // frame options
    wire m9      = c1[C1_M];
    wire int_lp  = c1[C1_LOOPBACK_SELECT] && !c1[C1_RX_SOURCE_SELECT];
    wire single  = c1[C1_LOOPBACK_SELECT] && c1[C1_RX_SOURCE_SELECT];
    wire pos_b   = sopt[SOPT_POS];
    wire [3:0] flen = m9 ? LEN_9 : LEN_8;
    wire [3:0] blen = 4'(flen + (long_break_select ? LEN_BRKX : 4'h0));
    wire [7:0] iticks = m9 ? TICKS_9 : TICKS_8;

    wire run = started && !(c1[C1_WFRZ] && cpu_wait);
    wire tick;

    asu_baud_gen #(.W(13)) u_baud (
        .clk     (clk),
        .reset_n (reset_n),
        .run     (run),
        .div     ({br_hi, bdl}),
        .tick    (tick)
    );

    wire rx_raw = c1[C1_LOOPBACK_SELECT] ? (pos_b ? tx_b_in : tx_a_in)
                               : (pos_b ? rx_b_in : rx_a_in);
    wire rx_sync;

    asu_sync3 u_sync (
        .clk     (clk),
        .reset_n (reset_n),
        .din     (rx_raw),
        .q       (rx_sync)
    );

    // transmit line level
    wire tx_busy = tx_left != 4'h0;
    wire tx_line = tx_busy ? tx_shift[0] : 1'b1;
    wire rx_line = int_lp ? tx_line : rx_sync;

    wire p7  = ^tx_buf[6:0] ^ c1[C1_PT];
    wire p8  = ^tx_buf[7:0] ^ c1[C1_PT];
    wire b7  = c1[C1_PE] ? p7 : tx_buf[7];
    wire b8  = c1[C1_PE] ? p8 : tx_buf[8];
    wire [13:0] frame = m9 ? {3'h7, 1'b1, b8, tx_buf[7:0], 1'b0}
                           : {4'hF, 1'b1, b7, tx_buf[6:0], 1'b0};

    // control register writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            bdh   <= RST_BDH;
            bdl   <= RST_BDL;
            br_hi <= '0;
            c1    <= RST_ZERO;
            c3    <= RST_ZERO;
            sopt  <= RST_ZERO;
            long_break_select <= 1'b0;
            lbkde <= 1'b0;
            started <= 1'b0;
        end else begin
            if (wr_bdh) bdh <= bus.wdata;
            if (wr_bdl) begin
                bdl   <= bus.wdata;
                br_hi <= bdh[BR_HI_W-1:0];
            end
            if (wr_c1) c1 <= bus.wdata;
            if (wr_c3) c3 <= bus.wdata;
            if (wr_opt) sopt <= bus.wdata;
            if (wr_s2) begin
                long_break_select <= bus.wdata[S2_LONG_BREAK_SELECT];
                lbkde <= bus.wdata[S2_LBKDE];
            end
            if (wr_c2 && (bus.wdata[C2_TE] || bus.wdata[C2_RE])) started <= 1'b1;
        end
    end

    // status read arms the clear sequences
    always_ff @(posedge clk) begin
        if (!reset_n) s1_seen <= 1'b0;
        else if (rd_s1) s1_seen <= 1'b1;
        else if (rd_dat || wr_dat) s1_seen <= 1'b0;
    end

    // transmitter: buffer, queues, shifter
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tx_shift <= '1;
            tx_left  <= 4'h0;
            tx_sub   <= 4'h0;
            tx_buf   <= '0;
            tdre     <= 1'b1;
            idle_q   <= 1'b0;
            brk_q    <= 1'b0;
        end else begin
            if (wr_dat) begin
                tx_buf <= {c3[C3_T8], bus.wdata};
                if (s1_seen) tdre <= 1'b0;
            end
            // queued idle on te rising
            if (wr_c2 && bus.wdata[C2_TE] && !c2[C2_TE]) idle_q <= 1'b1;
            // queued break on sbk write
            if (wr_c2 && bus.wdata[C2_SBK]) brk_q <= 1'b1;
            if (tick && tx_busy) begin
                tx_sub <= 4'(tx_sub + 1'b1);
                if (tx_sub == SUB_LAST) begin
                    tx_shift <= {1'b1, tx_shift[13:1]};
                    tx_left  <= 4'(tx_left - 1'b1);
                end
            end else if (tick && c2[C2_TE]) begin
                tx_sub <= 4'h0;
                if (brk_q || c2[C2_SBK]) begin
                    tx_shift <= '0;
                    tx_left  <= blen;
                    brk_q    <= 1'b0;
                end else if (idle_q) begin
                    tx_shift <= '1;
                    tx_left  <= flen;
                    idle_q   <= 1'b0;
                end else if (!tdre) begin
                    tx_shift <= frame;
                    tx_left  <= flen;
                    tdre     <= 1'b1;
                end
            end
        end
    end

    // transmission complete and control two
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            tc <= 1'b1;
            c2 <= RST_ZERO;
        end else begin
            tc <= tdre && !tx_busy && !idle_q && !brk_q && !c2[C2_SBK];
            if (wr_c2) c2 <= bus.wdata;
            else if (wake_hit) c2[C2_RWU] <= 1'b0;
        end
    end

    // majority of three mid-bit samples
    wire [2:0] trio = {samp, rx_line};
    wire maj  = (trio[0] & trio[1]) | (trio[1] & trio[2]) | (trio[0] & trio[2]);
    wire noisy = !(trio == 3'b000 || trio == 3'b111);
    wire mid  = tick && rx_st != RX_IDLE && rx_sub == SUB_S2;
    wire [3:0] nbits = m9 ? 4'h9 : 4'h8;
    wire done = mid && rx_st == RX_STOP;
    // received character, lsb aligned
    wire [8:0] rchr = m9 ? rx_shift : {1'b0, rx_shift[8:1]};
    wire msb  = m9 ? rchr[8] : rchr[7];
    wire perr = c1[C1_PE] && ((m9 ? ^rchr[8:0] : ^rchr[7:0]) != c1[C1_PT]);
    wire idle_hit = tick && rx_line && idle_cnt == 8'(iticks - 1'b1);
    wire addr_wk  = c1[C1_WAKE] && done && msb;
    assign wake_hit = c2[C2_RWU] && (addr_wk || (!c1[C1_WAKE] && idle_hit));
    wire accept   = done && (!c2[C2_RWU] || addr_wk);

    // receiver bit engine
    always_ff @(posedge clk) begin
        if (!reset_n || !c2[C2_RE]) begin
            rx_st    <= RX_IDLE;
            rx_sub   <= 4'h0;
            rx_bit   <= 4'h0;
            rx_shift <= '0;
            samp     <= 2'b11;
            rx_nf    <= 1'b0;
        end else if (tick) begin
            case (rx_st)
                RX_IDLE: begin
                    // low line seen in idle starts a frame
                    if (!rx_line) begin
                        rx_st  <= RX_START;
                        rx_sub <= 4'h1;
                        rx_nf  <= 1'b0;
                    end
                end
                default: begin
                    rx_sub <= 4'(rx_sub + 1'b1);
                    if (rx_sub == SUB_S0 || rx_sub == SUB_S1) samp <= {samp[0], rx_line};
                    if (rx_sub == SUB_S2) begin
                        if (noisy) rx_nf <= 1'b1;
                        case (rx_st)
                            RX_START: begin
                                rx_st  <= maj ? RX_IDLE : RX_DATA;
                                rx_bit <= 4'h0;
                            end
                            RX_DATA: begin
                                rx_shift <= {maj, rx_shift[8:1]};
                                rx_bit   <= 4'(rx_bit + 1'b1);
                                if (rx_bit == 4'(nbits - 1'b1)) rx_st <= RX_STOP;
                            end
                            default: rx_st <= RX_IDLE;
                        endcase
                    end
                end
            endcase
        end
    end

    // receive data and status flags
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            {rdrf, ovr, nf, fe, pf, idle, idle_arm} <= '0;
            rdat <= '0;
        end else begin
            // clear sequence: status read then data read
            if (rd_dat && s1_seen) {rdrf, ovr, nf, fe, pf, idle} <= '0;
            if (idle_hit && idle_arm && !c2[C2_RWU]) begin
                idle     <= 1'b1;
                idle_arm <= 1'b0;
            end
            // new character wins over clear
            if (accept) begin
                if (rdrf && !(rd_dat && s1_seen)) ovr <= 1'b1;
                else begin
                    rdrf <= 1'b1;
                    rdat <= rchr;
                    nf   <= rx_nf || noisy;
                    fe   <= !maj;
                    pf   <= perr;
                    idle_arm <= 1'b1;
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            idle_cnt <= '0;
            lbk_cnt  <= '0;
        end else if (tick) begin
            if (!rx_line || (c1[C1_ILT] && rx_st != RX_IDLE)) idle_cnt <= '0;
            else if (idle_cnt != iticks) idle_cnt <= 8'(idle_cnt + 1'b1);
            if (rx_line) lbk_cnt <= '0;
            else if (lbk_cnt != TICKS_LBK) lbk_cnt <= 8'(lbk_cnt + 1'b1);
        end
    end

    wire lbk_hit = lbkde && tick && !rx_line && lbk_cnt == 8'(TICKS_LBK - 1'b1);
    wire edg_hit = rx_prev && !rx_line && c2[C2_RE];

    // event flags, set wins over write-one clear
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            line_break_flag  <= 1'b0;
            edgif   <= 1'b0;
            rx_prev <= 1'b1;
        end else begin
            rx_prev <= rx_line;
            if (lbk_hit) line_break_flag <= 1'b1;
            else if (wr_s2 && bus.wdata[S2_LBK]) line_break_flag <= 1'b0;
            if (edg_hit) edgif <= 1'b1;
            else if (wr_s2 && bus.wdata[S2_EDG]) edgif <= 1'b0;
        end
    end

    wire drive = (c2[C2_TE] || tx_busy) && !int_lp && (!single || c3[C3_SINGLE_WIRE_DIRECTION]);

    logic [7:0] rd_mux;
    always_comb begin
        case (bus.addr)
            ADR_BDH:  rd_mux = bdh;
            ADR_BDL:  rd_mux = bdl;
            ADR_C1:   rd_mux = c1;
            ADR_C2:   rd_mux = c2;
            ADR_S1:   rd_mux = {tdre, tc, rdrf, idle, ovr, nf, fe, pf};
            ADR_S2:   rd_mux = {line_break_flag, edgif, 3'b000, long_break_select, lbkde, rx_st != RX_IDLE};
            ADR_C3:   rd_mux = {rdat[8], c3[6:0]};
            ADR_DAT:  rd_mux = rdat[7:0];
            ADR_SOPT: rd_mux = sopt;
            default:  rd_mux = 8'h00;
        endcase
    end

    // registered outputs
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            rdata    <= 8'h00;
            tx_a     <= '{out: 1'b1, oe: 1'b0};
            tx_b     <= '{out: 1'b1, oe: 1'b0};
            lbk_irq  <= 1'b0;
            edge_irq <= 1'b0;
        end else begin
            rdata <= bus.rd ? rd_mux : 8'h00;
            tx_a  <= '{out: tx_line, oe: drive && !pos_b};
            tx_b  <= '{out: tx_line, oe: drive && pos_b};
            lbk_irq  <= line_break_flag && bdh[BDH_LBKIE];
            edge_irq <= edgif && bdh[BDH_EDGIE];
        end
    end
endmodule // asu_top
`default_nettype wire

// ### asu_top_bench.sv
// Purpose: self-checking bench for the async serial unit
// Assumes: divisor 1 for most traffic
// Notes:   pins idle high through pull-ups
`timescale 1ns/1ns
`default_nettype none
module asu_top_bench;
    import asu_pkg::*;
    `define CHK(a, e) begin comparisons++; if ((a) !== (e)) begin err_count++; \
        $display("wrong value at %0t: got %h want %h", $time, a, e); end end
    logic       clk = 1'b0;
    logic       reset_n = 1'b0;
    asu_bus_s   bus = '0;
    logic [7:0] rdata, s;
    logic       lbk_irq, edge_irq, ok, peer_rx;
    logic       pos = 1'b0;      // pin pair in use
    logic       cpu_wait = 1'b0; // processor wait level
    asu_pin_s   tx_a, tx_b;
    logic [8:0] got;
    int         err_count = 0;
    int         comparisons = 0;
    wire logic  tx_a_in = tx_a.oe ? tx_a.out : 1'b1;
    wire logic  tx_b_in = tx_b.oe ? tx_b.out : 1'b1;
    wire logic  rx_a_in = pos ? 1'b1 : peer_rx;
    wire logic  rx_b_in = pos ? peer_rx : 1'b1;
    always #10 clk = ~clk;
    asu_top u_dut (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata), .cpu_wait(cpu_wait),
        .rx_a_in(rx_a_in), .rx_b_in(rx_b_in), .tx_a_in(tx_a_in), .tx_b_in(tx_b_in),
        .tx_a(tx_a), .tx_b(tx_b), .lbk_irq(lbk_irq), .edge_irq(edge_irq));
    asu_peer u_peer (.clk(clk), .line(pos ? tx_b_in : tx_a_in), .rx(peer_rx));
    task automatic close_out;
        $display("mismatches %0d comparisons %0d", err_count, comparisons);
        if (err_count == 0 && comparisons > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clk);
        bus.wr <= 1'b0;
        @(posedge clk);
    endtask
    task automatic rd(input logic [3:0] a, output logic [7:0] d);
        bus <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk);
        bus.rd <= 1'b0;
        @(negedge clk);
        d = rdata;
        @(posedge clk);
    endtask
    task automatic rdc(input logic [3:0] a, input logic [7:0] e);
        logic [7:0] r;
        rd(a, r);
        `CHK(r, e)
    endtask
    // poll for a received character, bounded
    task automatic rx_wait;
        s = 8'h00;
        for (int k = 0; k < 200 && !s[5]; k++) rd(ADR_S1, s);
        `CHK(s[5], 1'b1)
        if (!s[5]) close_out;
    endtask
    // send one character and decode it on the wire
    task automatic tx_chk(input logic [7:0] c1, d, input logic [8:0] e, input int n, bc);
        wr(ADR_C1, c1);
        rdc(ADR_C1, c1);
        rd(ADR_S1, s);
        wr(ADR_DAT, d);
        u_peer.recv(got, n, bc, ok);
        `CHK(ok, 1'b1)
        `CHK(got, e)
        if (!ok) close_out;
    endtask
    // parity bit replaces the msb
    function automatic logic [8:0] pty(input logic [7:0] d, input logic odd);
        return {1'b0, (^d[6:0]) ^ odd, d[6:0]};
    endfunction
    initial begin
        repeat (60000) @(posedge clk);
        err_count++;
        close_out;
    end
    initial begin
        repeat (6) @(posedge clk);
        reset_n <= 1'b1;
        @(posedge clk);
        rdc(ADR_BDH, RST_BDH);
        rdc(ADR_BDL, RST_BDL);
        rdc(ADR_C1, RST_ZERO);
        wr(4'hF, 8'hFF);
        rdc(4'hF, 8'h00);
        wr(ADR_BDH, 8'hC0);
        wr(ADR_BDL, 8'h01);
        wr(ADR_C3, 8'h40);
        wr(ADR_C2, 8'h0C);
        tx_chk(8'h00, 8'hA5, 9'h0A5, 8, 16);
        tx_chk(8'h10, 8'hA5, 9'h1A5, 9, 16);
        tx_chk(8'h02, 8'hA5, pty(8'hA5, 1'b0), 8, 16);
        tx_chk(8'h03, 8'hA5, pty(8'hA5, 1'b1), 8, 16);
        // high half buffered only, rate unchanged
        wr(ADR_BDH, 8'hDF);
        tx_chk(8'h00, 8'h3C, 9'h03C, 8, 16);
        wr(ADR_BDH, 8'hC0);
        wr(ADR_BDL, 8'h02);
        tx_chk(8'h00, 8'h3C, 9'h03C, 8, 32);
        wr(ADR_BDL, 8'h01);
        // alternate pin pair both ways
        wr(ADR_SOPT, 8'h01);
        pos <= 1'b1;
        tx_chk(8'h00, 8'h96, 9'h096, 8, 16);
        u_peer.send(9'h0C3, 8, 16);
        rx_wait();
        rdc(ADR_DAT, 8'hC3);
        `CHK(edge_irq, 1'b1)
        wr(ADR_S2, 8'h40);
        @(posedge clk);
        `CHK(edge_irq, 1'b0)
        wr(ADR_SOPT, 8'h00);
        pos <= 1'b0;
        // odd parity receive, good then bad
        wr(ADR_C1, 8'h03);
        for (int i = 0; i < 2; i++) begin
            u_peer.send({1'b0, i[0], 7'h01}, 8, 16);
            rx_wait();
            `CHK(s[0], i[0])
            rd(ADR_DAT, s);
        end
        // long low detected as a line break
        wr(ADR_C1, 8'h00);
        wr(ADR_S2, 8'h02);
        u_peer.send(9'h000, 8, 32);
        `CHK(lbk_irq, 1'b1)
        rd(ADR_S1, s);
        rd(ADR_DAT, s);
        wr(ADR_S2, 8'hC2);
        wr(ADR_BDH, 8'h00);
        u_peer.send(9'h000, 8, 32);
        rd(ADR_S2, s);
        `CHK(s[7], 1'b1)
        `CHK(lbk_irq, 1'b0)
        rd(ADR_S1, s);
        rd(ADR_DAT, s);
        // internal loopback returns own data
        wr(ADR_C1, 8'h80);
        rd(ADR_S1, s);
        wr(ADR_DAT, 8'h5A);
        rx_wait();
        rdc(ADR_DAT, 8'h5A);
        wr(ADR_C1, 8'h00);
        // long break: thirteen bit times low, stop slot still low
        wr(ADR_S2, 8'h06);
        wr(ADR_C2, 8'h0D);
        wr(ADR_C2, 8'h0C);
        u_peer.recv(got, 9, 16, ok);
        `CHK(ok, 1'b0)
        `CHK(got, 9'h000)
        repeat (60) @(posedge clk);
        // wait freeze holds the transmitter until the wait ends
        wr(ADR_C1, 8'h40);
        cpu_wait <= 1'b1;
        rd(ADR_S1, s);
        wr(ADR_DAT, 8'h81);
        u_peer.recv(got, 8, 16, ok);
        `CHK(ok, 1'b0)
        cpu_wait <= 1'b0;
        u_peer.recv(got, 8, 16, ok);
        `CHK(got, 9'h081)
        // zero divisor sends nothing
        wr(ADR_BDL, 8'h00);
        rd(ADR_S1, s);
        wr(ADR_DAT, 8'hFF);
        u_peer.recv(got, 8, 16, ok);
        `CHK(ok, 1'b0)
        close_out;
    end
endmodule // asu_top_bench
`default_nettype wire

// ### asu_top_chk.sv
// Purpose: port checker for the async serial unit
// Assumes: bench uses divisor 1 or 2 while traffic runs
// Notes:   helpers shadow the written control fields
`timescale 1ns/1ns
`default_nettype none
module asu_top_chk
    import asu_pkg::*;
(
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire asu_bus_s   bus,
    input  wire logic [7:0] rdata,
    input  wire asu_pin_s   tx_a,
    input  wire asu_pin_s   tx_b,
    input  wire logic       lbk_irq,
    input  wire logic       edge_irq
);
    logic [7:0]  hi_q;   // high divisor shadow
    logic [7:0]  c1_q;   // control one shadow
    logic [12:0] div_q;  // working divisor
    logic        arm_q;  // an engine was enabled
    logic        pos_q;  // pin position
    logic [9:0]  low_q;  // low run on pin a
    wire  logic  loop_in = c1_q[C1_LOOPBACK_SELECT] && !c1_q[C1_RX_SOURCE_SELECT];
    // shadow registers follow register writes
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            hi_q  <= RST_BDH;
            c1_q  <= RST_ZERO;
            div_q <= {RST_BDH[4:0], RST_BDL};
            arm_q <= 1'b0;
            pos_q <= 1'b0;
        end else if (bus.wr) begin
            if (bus.addr == ADR_BDH) hi_q <= bus.wdata;
            if (bus.addr == ADR_BDL) div_q <= {hi_q[4:0], bus.wdata};
            if (bus.addr == ADR_C1) c1_q <= bus.wdata;
            if (bus.addr == ADR_C2 && bus.wdata[3:2] != 2'b00) arm_q <= 1'b1;
            if (bus.addr == ADR_SOPT) pos_q <= bus.wdata[SOPT_POS];
        end
    end
    // cycles the pin a line has been low
    always_ff @(posedge clk) begin
        if (!reset_n || tx_a.out) low_q <= '0;
        else low_q <= low_q + 10'd1;
    end
    rd_idle_a: assert property (@(posedge clk) disable iff (!reset_n)
        !$past(bus.rd) |-> rdata == 8'h00) else $error("read data outside its cycle");
    unmapped_rd_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus.rd && bus.addr > ADR_SOPT |=> rdata == 8'h00) else $error("unmapped read");
    c1_back_a: assert property (@(posedge clk) disable iff (!reset_n)
        bus.wr && bus.addr == ADR_C1 ##2 bus.rd && bus.addr == ADR_C1
        |=> rdata == $past(bus.wdata, 3)) else $error("control one readback");
    lbk_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        lbk_irq |-> $past(hi_q[BDH_LBKIE])) else $error("break request not gated");
    edge_gate_a: assert property (@(posedge clk) disable iff (!reset_n)
        edge_irq |-> $past(hi_q[BDH_EDGIE])) else $error("edge request not gated");
    gen_off_a: assert property (@(posedge clk) disable iff (!reset_n)
        !arm_q |-> tx_a.out && tx_b.out) else $error("line active before enable");
    div_zero_a: assert property (@(posedge clk) disable iff (!reset_n)
        (div_q == 13'h0)[*2] |-> tx_a.out && tx_b.out) else $error("zero divisor ran");
    loop_pin_a: assert property (@(posedge clk) disable iff (!reset_n)
        loop_in [*3] |-> !tx_a.oe && !tx_b.oe) else $error("pin driven in loopback");
    pos_a_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!pos_q) [*3] |-> !tx_b.oe) else $error("alternate pin driven");
    pos_b_a: assert property (@(posedge clk) disable iff (!reset_n)
        pos_q [*3] |-> !tx_a.oe) else $error("default pin driven");
    bit16_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(tx_a.out) && div_q == 13'h1 |-> low_q[3:0] == 4'h0) else $error("bit length");
    bit32_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(tx_a.out) && div_q == 13'h2 |-> low_q[4:0] == 5'h00) else $error("baud rate");
endmodule // asu_top_chk
bind asu_top asu_top_chk u_chk (.clk(clk), .reset_n(reset_n), .bus(bus), .rdata(rdata),
    .tx_a(tx_a), .tx_b(tx_b), .lbk_irq(lbk_irq), .edge_irq(edge_irq));
`default_nettype wire
